/* File: totaliser_pkg.sv */
// Shared constants and types for the totaliser front-panel control.
package totaliser_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int SEG_TEST_MS = 3000;
  localparam int DP_TEST_MS = 3000;
  localparam int START_DELAY_MS = 100;
  localparam int ZERO_HOLD_MS = 2000;
  localparam int DEBOUNCE_MS = 20;
  localparam int SEG_TEST_CYCLES = SEG_TEST_MS * (CLK_HZ / 1000);
  localparam int DP_TEST_CYCLES = DP_TEST_MS * (CLK_HZ / 1000);
  localparam int START_DELAY_CYCLES = START_DELAY_MS * (CLK_HZ / 1000);
  localparam int ZERO_HOLD_CYCLES = ZERO_HOLD_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int DISC_FRAME_CYCLES = 20_000_000;
  localparam int RATE_DIGITS = 5;
  localparam int TOTAL_DIGITS = 8;
  localparam int GRAND_DIGITS = 16;
  localparam logic [11:0] ADC_4MA = 12'h333;
  localparam logic [11:0] ADC_20MA = 12'hFFF;
  localparam int DP_STEP_BITS = 3;
  typedef enum logic [4:0] {
    ST_WAIT = 5'h01,
    ST_SEGS = 5'h02,
    ST_DPS = 5'h04,
    ST_RUN = 5'h08,
    ST_SAVE = 5'h10
  } phase_type;
  typedef enum logic [1:0] {
    RV_LIVE = 2'h0,
    RV_CURRENT = 2'h1,
    RV_CAL4 = 2'h2,
    RV_CAL20 = 2'h3
  } rate_view_type;
  typedef enum logic [1:0] {
    TV_TOTAL = 2'h0,
    TV_GRAND_LOW = 2'h1,
    TV_GRAND_HIGH = 2'h2
  } total_view_type;
endpackage : totaliser_pkg

/* File: pin_sync.sv */
// Two-stage synchroniser followed by a hold-count debouncer for one pin.
module pin_sync #(
  parameter int STABLE_CYCLES = 4000000
) (
  input wire logic i_core_clk, // Core clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_pin, // Raw pin level.
  output logic o_level // Debounced level.
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  initial begin
    if (STABLE_CYCLES < 1) $error("pin_sync: STABLE_CYCLES must be at least 1");
  end
  logic meta;
  logic synced;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_level;
  always_comb begin
    next_count = count;
    next_level = o_level;
    if (synced == o_level) begin
      next_count = '0;
    end else if (count == CW'(STABLE_CYCLES - 1)) begin
      next_count = '0;
      next_level = synced;
    end else begin
      next_count = count + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      synced <= 1'b0;
      count <= '0;
      o_level <= 1'b0;
    end else begin
      meta <= i_pin;
      synced <= meta;
      count <= next_count;
      o_level <= next_level;
    end
  end
endmodule : pin_sync

/* File: totaliser_display_control.sv */
// Front-panel control for the loop-powered rate totaliser: power-up test, views, totals and saving.
module totaliser_display_control
  import totaliser_pkg::*;
#(
  parameter int SEG_CYCLES = SEG_TEST_CYCLES,
  parameter int DP_CYCLES = DP_TEST_CYCLES,
  parameter int START_CYCLES = START_DELAY_CYCLES,
  parameter int ZERO_CYCLES = ZERO_HOLD_CYCLES,
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int DISC_STEP_CYCLES = DISC_FRAME_CYCLES
) (
  input wire logic i_core_clk, // 200 MHz core clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_loop_ok, // Loop current present (pin level).
  input wire logic [11:0] i_adc_code, // Converter sample of loop current, same clock.
  input wire logic i_adc_valid, // One-cycle strobe with a new sample.
  input wire logic i_btn_view, // Current-view button pin, high while pressed.
  input wire logic i_btn_down, // Down button pin, high while pressed.
  input wire logic i_btn_up, // Up button pin, high while pressed.
  input wire logic i_btn_shift, // Shift button pin, high while pressed.
  input wire logic i_zero_contacts_closed, // Zero contacts zero_contact_a/zero_contact_b shorted.
  input wire logic i_cfg_percent, // Show current view as percent of span.
  input wire logic i_cfg_local_zero, // Local button reset enabled.
  input wire logic [19:0] i_nv_cal4, // Stored rate value at 4 mA.
  input wire logic [19:0] i_nv_cal20, // Stored rate value at 20 mA.
  input wire logic [31:0] i_nv_total, // Stored total, packed BCD.
  input wire logic [63:0] i_nv_grand, // Stored grand total, packed BCD.
  input wire logic [31:0] i_live_rate_total_step, // Accumulator increment per sample above 4 mA, binary; each accumulator overflow adds one to the total.
  output logic [19:0] o_rate_value, // Value on the five digit rate display.
  output logic [1:0] o_rate_view, // Which quantity the rate display shows.
  output logic [31:0] o_total_value, // Value on the eight digit total display.
  output logic o_grand_annunciator, // Grand-total annunciator lit.
  output logic o_all_segments, // Segment test: light everything.
  output logic [7:0] o_decimal_points, // Large display decimal points.
  output logic o_disc_running, // Flow disc animates.
  output logic [2:0] o_disc_phase, // Current disc animation frame.
  output logic o_nv_load, // One-cycle pulse: load calibration and totals.
  output logic o_nv_store, // One-cycle pulse: store total and grand total.
  output logic [31:0] o_nv_total, // Total to store.
  output logic [63:0] o_nv_grand // Grand total to store.
);
  initial begin
    if (SEG_CYCLES < 8 || DP_CYCLES < 8 || START_CYCLES < 1 || ZERO_CYCLES < 1 || DISC_STEP_CYCLES < 1)
      $error("totaliser_display_control: timing parameters too small");
  end

  logic loop_ok;
  logic b_view;
  logic b_down;
  logic b_up;
  logic b_shift;
  logic zero_pin;

  pin_sync #(.STABLE_CYCLES(1)) u_loop (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_loop_ok), .o_level(loop_ok));
  pin_sync #(.STABLE_CYCLES(DEB_CYCLES)) u_view (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_btn_view), .o_level(b_view));
  pin_sync #(.STABLE_CYCLES(DEB_CYCLES)) u_down (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_btn_down), .o_level(b_down));
  pin_sync #(.STABLE_CYCLES(DEB_CYCLES)) u_up (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_btn_up), .o_level(b_up));
  pin_sync #(.STABLE_CYCLES(DEB_CYCLES)) u_shift (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_btn_shift), .o_level(b_shift));
  pin_sync #(.STABLE_CYCLES(DEB_CYCLES)) u_zero (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pin(i_zero_contacts_closed), .o_level(zero_pin));

  // Add one to a packed-BCD word of the given digit count, wrapping at all nines.
  function automatic logic [63:0] bcd_inc(input logic [63:0] v, input int digits);
    logic [63:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int d = 0; d < GRAND_DIGITS; d++) begin
      if (carry && d < digits) begin
        if (r[d*4 +: 4] == 4'h9) begin
          r[d*4 +: 4] = 4'h0;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  phase_type phase;
  phase_type next_phase;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [19:0] cal4;
  logic [19:0] next_cal4;
  logic [19:0] cal20;
  logic [19:0] next_cal20;
  logic [31:0] total;
  logic [31:0] next_total;
  logic [63:0] grand;
  logic [63:0] next_grand;
  logic [31:0] accum;
  logic [31:0] next_accum;
  logic [11:0] adc;
  logic [11:0] next_adc;
  logic [31:0] zero_timer;
  logic [31:0] next_zero_timer;
  logic zero_done;
  logic next_zero_done;
  logic [31:0] disc_timer;
  logic [31:0] next_disc_timer;
  logic [2:0] next_disc_phase;
  logic next_nv_load;
  logic next_nv_store;
  logic both_held;
  logic local_zero;
  logic count_step;

  assign both_held = b_down && b_up && !b_shift;
  assign local_zero = i_cfg_local_zero && both_held && (zero_timer == 32'(ZERO_CYCLES - 1)) && !zero_done;

  always_comb begin
    next_phase = phase;
    next_timer = timer + 32'h1;
    next_nv_load = 1'b0;
    next_nv_store = 1'b0;
    next_cal4 = cal4;
    next_cal20 = cal20;
    next_total = total;
    next_grand = grand;
    next_accum = accum;
    next_adc = adc;
    count_step = 1'b0;
    case (phase)
      ST_WAIT: begin
        if (!loop_ok) begin
          next_timer = '0;
        end else if (timer == 32'(START_CYCLES - 1)) begin
          next_phase = ST_SEGS;
          next_timer = '0;
          next_nv_load = 1'b1;
        end
      end
      ST_SEGS: begin
        if (timer == 32'(SEG_CYCLES - 1)) begin
          next_phase = ST_DPS;
          next_timer = '0;
        end
      end
      ST_DPS: begin
        if (timer == 32'(DP_CYCLES - 1)) begin
          next_phase = ST_RUN;
          next_timer = '0;
          next_cal4 = i_nv_cal4;
          next_cal20 = i_nv_cal20;
          next_total = i_nv_total;
          next_grand = i_nv_grand;
          next_accum = '0;
        end
      end
      ST_RUN: begin
        next_timer = '0;
        if (!loop_ok) begin
          next_phase = ST_SAVE;
          next_nv_store = 1'b1;
        end else if (i_adc_valid) begin
          next_adc = i_adc_code;
          if (i_adc_code > ADC_4MA) begin
            next_accum = accum + i_live_rate_total_step;
            count_step = next_accum < accum;
          end
        end
        if (count_step) begin
          next_total = 32'(bcd_inc({32'h0, total}, TOTAL_DIGITS));
          next_grand = bcd_inc(grand, GRAND_DIGITS);
        end
        if (zero_pin || local_zero) begin
          next_total = '0;
          next_accum = '0;
        end
      end
      ST_SAVE: begin
        next_timer = '0;
        next_phase = ST_WAIT;
      end
      default: begin
        next_phase = ST_WAIT;
        next_timer = '0;
      end
    endcase
  end

  always_comb begin
    next_zero_timer = '0;
    next_zero_done = zero_done && both_held;
    if (both_held && phase == ST_RUN) begin
      next_zero_timer = (zero_timer == 32'(ZERO_CYCLES - 1)) ? zero_timer : zero_timer + 32'h1;
      if (local_zero) begin
        next_zero_done = 1'b1;
      end
    end
    next_disc_timer = '0;
    next_disc_phase = o_disc_phase;
    if (phase == ST_RUN && adc > ADC_4MA) begin
      next_disc_timer = disc_timer + 32'h1;
      if (disc_timer == 32'(DISC_STEP_CYCLES - 1)) begin
        next_disc_timer = '0;
        next_disc_phase = o_disc_phase + 3'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= ST_WAIT;
      timer <= '0;
      cal4 <= '0;
      cal20 <= '0;
      total <= '0;
      grand <= '0;
      accum <= '0;
      adc <= '0;
      zero_timer <= '0;
      zero_done <= 1'b0;
      disc_timer <= '0;
      o_disc_phase <= '0;
      o_nv_load <= 1'b0;
      o_nv_store <= 1'b0;
    end else begin
      phase <= next_phase;
      timer <= next_timer;
      cal4 <= next_cal4;
      cal20 <= next_cal20;
      total <= next_total;
      grand <= next_grand;
      accum <= next_accum;
      adc <= next_adc;
      zero_timer <= next_zero_timer;
      zero_done <= next_zero_done;
      disc_timer <= next_disc_timer;
      o_disc_phase <= next_disc_phase;
      o_nv_load <= next_nv_load;
      o_nv_store <= next_nv_store;
    end
  end

  // Display selection; combinations take priority over single buttons so a chord never flashes a view.
  logic [1:0] next_rate_view;
  logic [19:0] next_rate_value;
  logic [31:0] next_total_value;
  logic next_grand_ann;
  logic next_all_segments;
  logic [7:0] next_dps;
  logic [31:0] live_rate;
  logic [31:0] span;
  logic [11:0] above;

  always_comb begin
    above = (adc > ADC_4MA) ? adc - ADC_4MA : 12'h000;
    span = 32'(above) * 32'(cal20 - cal4) / 32'(ADC_20MA - ADC_4MA);
    live_rate = 32'(cal4) + 32'(span[19:0]);
    next_rate_view = RV_LIVE;
    next_rate_value = live_rate[19:0];
    next_total_value = total;
    next_grand_ann = 1'b0;
    next_all_segments = 1'b0;
    next_dps = 8'h00;
    if (b_shift && b_down && !b_up) begin
      next_total_value = grand[31:0];
      next_grand_ann = 1'b1;
    end else if (b_shift && b_up && !b_down) begin
      next_total_value = grand[63:32];
      next_grand_ann = 1'b1;
    end else if (b_down && b_up) begin
      next_rate_view = RV_LIVE;
    end else if (b_view && !b_shift) begin
      next_rate_view = RV_CURRENT;
      next_rate_value = i_cfg_percent ? 20'(32'(above) * 32'h64 / 32'(ADC_20MA - ADC_4MA))
                                      : 20'(32'h4 + 32'(above) * 32'h10 / 32'(ADC_20MA - ADC_4MA));
    end else if (b_down && !b_shift) begin
      next_rate_view = RV_CAL4;
      next_rate_value = cal4;
    end else if (b_up && !b_shift) begin
      next_rate_view = RV_CAL20;
      next_rate_value = cal20;
    end
    if (phase == ST_SEGS) begin
      next_all_segments = 1'b1;
    end else if (phase == ST_DPS) begin
      next_dps = 8'h01 << timer[31:0] / 32'(DP_CYCLES / TOTAL_DIGITS);
    end
    if (phase != ST_RUN) begin
      next_rate_view = RV_LIVE;
      next_rate_value = '0;
      next_total_value = '0;
      next_grand_ann = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rate_view <= RV_LIVE;
      o_rate_value <= '0;
      o_total_value <= '0;
      o_grand_annunciator <= 1'b0;
      o_all_segments <= 1'b0;
      o_decimal_points <= '0;
      o_disc_running <= 1'b0;
      o_nv_total <= '0;
      o_nv_grand <= '0;
    end else begin
      o_rate_view <= next_rate_view;
      o_rate_value <= next_rate_value;
      o_total_value <= next_total_value;
      o_grand_annunciator <= next_grand_ann;
      o_all_segments <= next_all_segments;
      o_decimal_points <= next_dps;
      o_disc_running <= (phase == ST_RUN) && (adc > ADC_4MA);
      o_nv_total <= total;
      o_nv_grand <= grand;
    end
  end
endmodule : totaliser_display_control

/* File: loop_source.sv */
// Behavioural loop current source with its converter, the block's far side.
module loop_source (
  input wire logic i_core_clk, // Converter clock.
  input wire logic i_on, // Loop current applied.
  input wire logic [11:0] i_code, // Sample value while powered.
  output logic o_loop_ok, // Loop current present.
  output logic [11:0] o_adc_code, // Converter sample.
  output logic o_adc_valid // One-cycle sample strobe.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div = 3'h0;
  initial begin
    o_loop_ok = 1'b0;
    o_adc_code = 12'h000;
    o_adc_valid = 1'b0;
  end
  // Unpowered, the code toggles every cycle so a stale sample can never pass for a live one.
  always @(posedge i_core_clk) begin
    div <= div + 3'h1;
    o_loop_ok <= i_on;
    o_adc_valid <= i_on && (div == 3'h7);
    o_adc_code <= i_on ? i_code : ~o_adc_code;
  end
endmodule : loop_source

/* File: totaliser_display_control_asserts.sv */
// Port-level checker for the totaliser front-panel control, with its bind.
module totaliser_display_control_asserts #(
  parameter int SEG_CYCLES = 64
) (
  input wire logic i_core_clk, // Core clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic i_loop_ok, // Loop present pin.
  input wire logic i_btn_shift, // Shift pin.
  input wire logic i_zero_contacts_closed, // Zero contacts pin.
  input wire logic [1:0] o_rate_view, // Rate view.
  input wire logic [31:0] o_total_value, // Total display.
  input wire logic o_grand_annunciator, // Grand annunciator.
  input wire logic o_all_segments, // Segment test.
  input wire logic [7:0] o_decimal_points, // Decimal points.
  input wire logic o_disc_running, // Disc animates.
  input wire logic [2:0] o_disc_phase, // Disc frame.
  input wire logic o_nv_load, // Load pulse.
  input wire logic o_nv_store // Store pulse.
);
  logic [31:0] seg_cnt;
  logic [31:0] next_seg_cnt;
  logic [3:0] shift_off;
  logic [3:0] next_shift_off;
  logic [3:0] zc_cnt;
  logic [3:0] next_zc_cnt;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // The 4-bit shift and contact counts saturate to stay small however long a level stands; seg_cnt counts freely.
  always_comb begin
    next_seg_cnt = o_all_segments ? seg_cnt + 32'h1 : 32'h0;
    next_shift_off = i_btn_shift ? 4'h0 : ((shift_off == 4'hF) ? shift_off : shift_off + 4'h1);
    next_zc_cnt = !i_zero_contacts_closed ? 4'h0 : ((zc_cnt == 4'hF) ? zc_cnt : zc_cnt + 4'h1);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_cnt <= 32'h0;
      shift_off <= 4'hF;
      zc_cnt <= 4'h0;
    end else begin
      seg_cnt <= next_seg_cnt;
      shift_off <= next_shift_off;
      zc_cnt <= next_zc_cnt;
    end
  end
  AST_LOAD_PULSE: assert property (o_nv_load |=> !o_nv_load && o_all_segments)
    else $error("load pulse not one cycle before segment test");
  AST_SEG_LENGTH: assert property (seg_cnt <= SEG_CYCLES + 1)
    else $error("segment test too long");
  AST_SEG_TO_DP: assert property ($fell(o_all_segments) && i_loop_ok |->
    $past(seg_cnt) >= SEG_CYCLES - 1 ##[0:1] o_decimal_points != 8'h00)
    else $error("segment test short or not followed by decimal walk");
  AST_DP_ONE: assert property ($onehot0(o_decimal_points))
    else $error("more than one decimal point lit");
  AST_NO_VIEW_IN_TEST: assert property (o_all_segments || o_decimal_points != 8'h00 |->
    o_rate_view == 2'h0 && !o_grand_annunciator)
    else $error("button view during test sequence");
  AST_STORE_ON_LOSS: assert property (o_nv_store |-> !$past(i_loop_ok) ##1 !o_nv_store)
    else $error("store pulse without loop loss or too long");
  AST_GRAND_RELEASE: assert property (o_grand_annunciator |-> shift_off < 4'hA)
    else $error("grand annunciator lit with shift released");
  AST_DISC_STILL: assert property (!o_disc_running [*2] |-> $stable(o_disc_phase))
    else $error("disc moves while stopped");
  AST_DISC_TURNS: assert property (o_disc_running [*8] |-> o_disc_phase != $past(o_disc_phase, 7))
    else $error("disc stands while running");
  AST_CONTACT_ZERO: assert property (zc_cnt >= 4'hA && !o_grand_annunciator |-> o_total_value == 32'h0)
    else $error("total not zero with contacts closed");
endmodule : totaliser_display_control_asserts

bind totaliser_display_control totaliser_display_control_asserts #(.SEG_CYCLES(SEG_CYCLES))
  totaliser_display_control_asserts_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_loop_ok(i_loop_ok), .i_btn_shift(i_btn_shift),
  .i_zero_contacts_closed(i_zero_contacts_closed), .o_rate_view(o_rate_view), .o_total_value(o_total_value),
  .o_grand_annunciator(o_grand_annunciator), .o_all_segments(o_all_segments),
  .o_decimal_points(o_decimal_points), .o_disc_running(o_disc_running), .o_disc_phase(o_disc_phase),
  .o_nv_load(o_nv_load), .o_nv_store(o_nv_store));

/* File: totaliser_display_control_tb.sv */
// Self-checking testbench for the totaliser front-panel control.
module totaliser_display_control_tb
  import totaliser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
  localparam int SEG = 64;
  localparam int DPC = 64;
  localparam int ZC = 20;
  int errors = 0;
  int num_checks = 0;
  int seed = 84883;
  int i;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] code = 12'h800;
  logic view = 1'b0;
  logic down = 1'b0;
  logic up = 1'b0;
  logic shift = 1'b0;
  logic zc = 1'b0;
  logic pct = 1'b0;
  logic lz = 1'b0;
  logic [19:0] cal4 = 20'h0;
  logic [19:0] cal20 = 20'h0;
  logic [31:0] ntot = 32'h0;
  logic [63:0] ngrand = 64'h0;
  logic [31:0] tot_exp = 32'h0;
  logic [31:0] step = 32'h0;
  logic [2:0] disc_ph, ph;
  logic loop_ok, adc_valid, ann, allseg, disc_run, nv_load, nv_store;
  logic [11:0] adc_code;
  logic [19:0] rate_value;
  logic [1:0] rate_view;
  logic [31:0] total_value, nv_total;
  logic [7:0] dps;
  logic [63:0] nv_grand;
  logic [3:0] combos [6] = '{4'h8, 4'h4, 4'h2, 4'h5, 4'h3, 4'h1};
  logic [11:0] codes [4];
  always #2.5 clk = ~clk;
  loop_source loop_source_inst (.i_core_clk(clk), .i_on(pwr), .i_code(code), .o_loop_ok(loop_ok),
    .o_adc_code(adc_code), .o_adc_valid(adc_valid));
  totaliser_display_control #(.SEG_CYCLES(SEG), .DP_CYCLES(DPC), .START_CYCLES(4), .ZERO_CYCLES(ZC),
    .DEB_CYCLES(2), .DISC_STEP_CYCLES(4)) totaliser_display_control_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_loop_ok(loop_ok), .i_adc_code(adc_code), .i_adc_valid(adc_valid),
    .i_btn_view(view), .i_btn_down(down), .i_btn_up(up), .i_btn_shift(shift), .i_zero_contacts_closed(zc),
    .i_cfg_percent(pct), .i_cfg_local_zero(lz), .i_nv_cal4(cal4), .i_nv_cal20(cal20), .i_nv_total(ntot),
    .i_nv_grand(ngrand), .i_live_rate_total_step(step), .o_rate_value(rate_value), .o_rate_view(rate_view),
    .o_total_value(total_value), .o_grand_annunciator(ann), .o_all_segments(allseg), .o_decimal_points(dps),
    .o_disc_running(disc_run), .o_disc_phase(disc_ph), .o_nv_load(nv_load), .o_nv_store(nv_store),
    .o_nv_total(nv_total), .o_nv_grand(nv_grand));
  function automatic logic [1:0] exp_view(input logic [3:0] b);
    case (b)
      4'h8: return RV_CURRENT;
      4'h4: return RV_CAL4;
      4'h2: return RV_CAL20;
      default: return RV_LIVE;
    endcase
  endfunction : exp_view
  function automatic logic [31:0] exp_total(input logic [3:0] b);
    return (b == 4'h5) ? ngrand[31:0] : ((b == 4'h3) ? ngrand[63:32] : tot_exp);
  endfunction : exp_total
  // Current view in whole percent of span or whole milliamps, worked out from the 4 mA and 20 mA codes.
  function automatic logic [19:0] exp_current(input logic [11:0] c, input logic p);
    int a;
    a = int'(c) - int'(ADC_4MA);
    return p ? 20'(a * 32'h64 / int'(ADC_20MA - ADC_4MA)) : 20'(32'h4 + a * 32'h10 / int'(ADC_20MA - ADC_4MA));
  endfunction : exp_current
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask : done
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Button vector order is view, down, up, shift.
  task automatic press(input logic [3:0] b, input int n);
    @(posedge clk);
    {view, down, up, shift} <= b;
    cyc(n);
  endtask : press
  task automatic power_up(input logic [31:0] tot);
    int k;
    logic [7:0] seen;
    seen = 8'h0;
    @(posedge clk);
    ntot <= tot;
    pwr <= 1'b1;
    for (k = 0; k < 100 && nv_load !== 1'b1; k++) cyc(1);
    `CHK(nv_load, 1'b1)
    cyc(2);
    `CHK(allseg, 1'b1)
    for (k = 0; k < 2 * SEG && allseg !== 1'b0; k++) cyc(1);
    `CHK(k inside {[SEG - 5:SEG]}, 1'b1)
    for (k = 0; k < 2 * DPC && (dps !== 8'h0 || k < 2); k++) begin
      seen |= dps;
      cyc(1);
    end
    `CHK(seen, 8'hFF)
    `CHK(k inside {[DPC - 3:DPC + 2]}, 1'b1)
    cyc(3);
    `CHK(total_value, tot)
    `CHK(rate_view, 2'(RV_LIVE))
    tot_exp = tot;
    done("power-up");
  endtask : power_up
  task automatic try_buttons(input logic [3:0] b);
    press(b, 12);
    `CHK(rate_view, exp_view(b))
    `CHK(total_value, exp_total(b))
    `CHK(ann, b inside {4'h5, 4'h3})
    if (b inside {4'h4, 4'h2}) `CHK(rate_value, b[2] ? cal4 : cal20)
    if (b == 4'h8) `CHK(rate_value, exp_current(code, pct))
    press(4'h0, 12);
    `CHK(rate_view, 2'(RV_LIVE))
  endtask : try_buttons
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    cal4 = 20'($unsigned($random(seed)));
    cal20 = 20'($unsigned($random(seed)));
    ngrand = {32'($random(seed)), 32'($random(seed))};
    pct = 1'($random(seed));
    codes = '{12'h334, 12'h334 + 12'($unsigned($random(seed)) % 3000), 12'h333, 12'h000};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    power_up(32'h1234_5678);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      code <= codes[i];
      cyc(40);
      `CHK(disc_run, codes[i] > ADC_4MA)
      ph = disc_ph;
      cyc(8);
      `CHK(disc_ph != ph, codes[i] > ADC_4MA)
    end
    @(posedge clk);
    code <= 12'h800;
    done("flow disc");
    for (i = 0; i < 6; i++) try_buttons(combos[i]);
    repeat (10) try_buttons(combos[$unsigned($random(seed)) % 6]);
    done("buttons");
    press(4'h6, ZC + 30);
    `CHK(total_value, tot_exp)
    `CHK(rate_view, 2'(RV_LIVE))
    press(4'h0, 10);
    @(posedge clk);
    lz <= 1'b1;
    press(4'h6, ZC / 2);
    `CHK(total_value, tot_exp)
    cyc(ZC + 10);
    `CHK(total_value, 32'h0)
    press(4'h0, 10);
    tot_exp = 32'h0;
    done("local zero");
    @(posedge clk);
    pwr <= 1'b0;
    for (i = 0; i < 30 && nv_store !== 1'b1; i++) cyc(1);
    `CHK(nv_store, 1'b1)
    `CHK(nv_total, 32'h0)
    `CHK(nv_grand, ngrand)
    cyc(1);
    `CHK(nv_store, 1'b0)
    done("loop loss");
    power_up(32'h0098_7654);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    `CHK(total_value, 32'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    power_up(32'h0000_0098);
    // Half-range steps overflow the accumulator on every second sample: ten samples add five, with a BCD carry.
    @(posedge clk);
    step <= 32'h8000_0000;
    cyc(80);
    @(posedge clk);
    step <= 32'h0;
    cyc(20);
    `CHK(total_value inside {[32'h0000_0102:32'h0000_0104]}, 1'b1)
    @(posedge clk);
    zc <= 1'b1;
    cyc(15);
    `CHK(total_value, 32'h0)
    @(posedge clk);
    zc <= 1'b0;
    cyc(15);
    `CHK(total_value, 32'h0)
    done("reset, totalising and zero contacts");
    final_report();
  end
endmodule : totaliser_display_control_tb
